// ### verification/acp_top_props.sv
// Checker for acp_top: conversion start, channel capture and pin hand-over.
// Assumes it is bound to acp_top and sees only its ports.
`timescale 1ns/1ps
module acp_chk #(parameter NPIN = 8) (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   input wire ack_o,
   input wire [NPIN-1:0] port_oe_i,
   input wire [NPIN-1:0] pin_out_o,
   input wire [NPIN-1:0] pin_oe_o,
   input wire [NPIN-1:0] analog_sel_o,
   input wire [4:0] channel_o,
   input wire conv_start_o
);
   wire wc = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == 8'h00;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_st; wc && dat_i[4:0] != 5'h1F |=> conv_start_o; endproperty
   a_st: assert property (p_st) else $error("no start");
   property p_id; wc && dat_i[4:0] == 5'h1F |=> !conv_start_o; endproperty
   a_id: assert property (p_id) else $error("idle start");
   property p_one; conv_start_o |=> !conv_start_o; endproperty
   a_one: assert property (p_one) else $error("long start");
   property p_ch; wc |=> channel_o == $past(dat_i[4:0]); endproperty
   a_ch: assert property (p_ch) else $error("channel");
   property p_keep; ((pin_oe_o ^ $past(port_oe_i)) & ~analog_sel_o & ~$past(analog_sel_o)) == 0; endproperty
   a_keep: assert property (p_keep) else $error("port lost");
   property p_rel; (pin_oe_o & analog_sel_o & $past(analog_sel_o)) == 0; endproperty
   a_rel: assert property (p_rel) else $error("pin driven");
   property p_b0; analog_sel_o[0] && $past(analog_sel_o[0]) |-> !pin_out_o[0] && !pin_oe_o[0]; endproperty
   a_b0: assert property (p_b0) else $error("pin zero");
endmodule
bind acp_top acp_chk #(.NPIN(NPIN)) chk_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .port_oe_i(port_oe_i), .pin_out_o(pin_out_o),
   .pin_oe_o(pin_oe_o), .analog_sel_o(analog_sel_o), .channel_o(channel_o), .conv_start_o(conv_start_o));

// ### verification/tb_top.sv
// Self-checking bench for acp_top: control writes, clock select, pin hand-over.
// Assumes acp_top with its bound checker; the bench drives all ports itself.
`timescale 1ns/1ps
module tb_top;
   reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, at = 0, as = 0, er;
   reg [7:0] adr = 0, po = 0, pe = 0, pm;
   reg [31:0] di = 0, rd, r = 32'hF3F3;
   wire [31:0] dat_o;
   wire ack_o, err_o, cs, ca, cd;
   wire [7:0] pin_out_o, pin_oe_o, asel;
   wire [4:0] ch;
   integer failures = 0, samples_checked = 0, cyc_n = 0, k, m;
   always #50 clk_i = ~clk_i;
   acp_top #(.CONV_CYCLES(2)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(4'hF), .dat_i(di), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .alt_tick_i(at), .async_tick_i(as),
      .port_out_i(po), .port_oe_i(pe), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .analog_sel_o(asel),
      .channel_o(ch), .conv_start_o(cs), .conv_active_o(ca), .conv_done_o(cd));
   function [31:0] nx(input [31:0] s);
      nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input [31:0] s, input [31:0] e, input string n);
      samples_checked = samples_checked + 1;
      if (s !== e) begin
         failures = failures + 1;
         $display("Error %s exp %h got %h", n, e, s);
      end
   endtask
   task wb(input w, input [7:0] a, input [31:0] d);
      integer n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      di <= d;
      do begin
         @(posedge clk_i);
         n = n + 1;
      end while (!(ack_o | err_o) && n < 20);
      rd = dat_o;
      er = err_o;
      cyc <= 0;
      stb <= 0;
   endtask
   task give_verdict;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Ceiling of 4000 cycles, well above the three tests, about 470 cycles
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 4000) begin
         failures = failures + 1;
         give_verdict;
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      for (k = 0; k < 32; k = k + 1) begin
         wb(1, 8'h00, k);
         chk(ch, k, "chan");
         chk(ca, k < 31, "active");
      end
      $display("test channel done");
      for (k = 0; k < 8; k = k + 1) begin
         m = k % 2;
         at <= m ? (k / 2 == 3) : (k / 2 == 2);
         as <= m ? (k / 2 == 2) : (k / 2 == 3);
         wb(1, 8'h04, k / 2);
         wb(1, 8'h00, 5);
         repeat (30) @(posedge clk_i);
         chk(cd, k < 4 || !m, "done");
      end
      $display("test clock done");
      repeat (8) begin
         r = nx(r);
         pm = r[7:0];
         po <= r[15:8];
         pe <= r[23:16];
         wb(1, 8'h08, pm);
         repeat (3) @(posedge clk_i);
         chk(asel, pm, "asel");
         chk(pin_oe_o, pe & ~pm, "oe");
         chk(pin_out_o, po & ~pm, "out");
         wb(0, 8'h08, 0);
         chk(rd, pm, "read");
      end
      wb(0, 8'h10, 0);
      chk(er, 1, "unmapped");
      $display("test pins done");
      give_verdict;
   end
endmodule

// ### verilog/acp_clk_sel.v
// Conversion clock enable selector: turns the chosen source into a one-cycle enable.
// Assumes alternate and asynchronous clock ticks arrive as pulses synchronous to clk_i.
`timescale 1ns/1ps
`include "acp_consts.vh"
module acp_clk_sel (
   input wire clk_i,
   input wire rst_i,
   input wire [1:0] sel_i,
   input wire alt_tick_i,
   input wire async_tick_i,
   output reg conv_en_o
);
   reg half;
   always @(posedge clk_i) begin
      if (rst_i) begin
         half <= 1'b0;
         conv_en_o <= 1'b0;
      end else begin
         half <= ~half;
         case (sel_i)
            `ACP_CLK_BUS: conv_en_o <= 1'b1;
            `ACP_CLK_HALF: conv_en_o <= half;
            `ACP_CLK_ALT: conv_en_o <= alt_tick_i;
            `ACP_CLK_ASYNC: conv_en_o <= async_tick_i;
            default: conv_en_o <= 1'b0;
         endcase
      end
   end
endmodule

// ### verilog/acp_consts.vh
// Constants for the converter control front end: register offsets, field layout, reset values.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
`ifndef ACP_CONSTS_VH
`define ACP_CONSTS_VH
`define ACP_OFS_CONV_SC 8'h00
`define ACP_OFS_CLK_CFG 8'h04
`define ACP_OFS_PIN_LOW 8'h08
`define ACP_OFS_STATUS 8'h0C
`define ACP_CH_LSB 0
`define ACP_CH_MSB 4
`define ACP_CH_IDLE 5'h1F
`define ACP_CH_MAX 5'h1B
`define ACP_CLK_BUS 2'h0
`define ACP_CLK_HALF 2'h1
`define ACP_CLK_ALT 2'h2
`define ACP_CLK_ASYNC 2'h3
`define ACP_CONV_SC_RST 5'h1F
`define ACP_CLK_CFG_RST 2'h0
`define ACP_PIN_RST 8'h00
`define ACP_CONV_CYCLES 8'h14
`endif

// ### verilog/acp_top.v
// Converter control front end: conversion restart on control write, channel select,
// conversion clock select and pin hand-over from port to analog use.
// Assumes a classic Wishbone master on clk_i; the analog core consumes the start pulse.
`timescale 1ns/1ps
`include "acp_consts.vh"
// Function
// - Any control write with byte lane 0 enabled aborts and restarts conversion unless channel field is all ones.
// - Channel field picks the analog input, up to 28 channels.
// - Two-bit clock select: bus, bus halved, alternate, asynchronous.
// - Pin control low register covers channels 0-7, bit number equals channel.
// - Bit 0 keeps port control; bit 1 hands the pin to analog use.
// - Port logic releases every pin whose pin control bit is set.
module acp_top #(
   parameter NPIN = 8,
   parameter CONV_CYCLES = 8
) (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   output reg err_o,
   input wire alt_tick_i,
   input wire async_tick_i,
   input wire [NPIN-1:0] port_out_i,
   input wire [NPIN-1:0] port_oe_i,
   output reg [NPIN-1:0] pin_out_o,
   output reg [NPIN-1:0] pin_oe_o,
   output reg [NPIN-1:0] analog_sel_o,
   output reg [4:0] channel_o,
   output reg conv_start_o,
   output reg conv_active_o,
   output reg conv_done_o
);
   // Register file and bus answer
   reg [4:0] conv_ch;
   reg [1:0] clk_sel;
   reg [NPIN-1:0] pin_ctl;
   reg [4:0] next_conv_ch;
   reg [1:0] next_clk_sel;
   reg [NPIN-1:0] next_pin_ctl;
   reg [31:0] next_dat;
   reg next_ack;
   reg next_err;

   // Conversion sequencer state
   localparam ST_IDLE = 2'b00;
   localparam ST_RUN = 2'b01;
   localparam ST_DONE = 2'b10;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [7:0] cnt;
   reg [7:0] next_cnt;
   reg next_start;
   reg [4:0] next_channel;
   wire conv_en;

   // A held strobe is answered every second cycle, never twice in a row
   wire req = cyc_i & stb_i & ~ack_o & ~err_o;
   wire hit_sc = (adr_i == `ACP_OFS_CONV_SC);
   wire hit_clk = (adr_i == `ACP_OFS_CLK_CFG);
   wire hit_pin = (adr_i == `ACP_OFS_PIN_LOW);
   wire hit_stat = (adr_i == `ACP_OFS_STATUS);
   wire mapped = hit_sc | hit_clk | hit_pin | hit_stat;
   // Only the low byte holds register bits, so only its lane enable matters
   wire wr_ok = req & mapped & we_i & sel_i[0];
   wire rd_ok = req & mapped & ~we_i;
   wire wr_sc = wr_ok & hit_sc;
   wire [4:0] wr_ch = dat_i[`ACP_CH_MSB:`ACP_CH_LSB];

   acp_clk_sel u_clk_sel (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(clk_sel),
      .alt_tick_i(alt_tick_i),
      .async_tick_i(async_tick_i),
      .conv_en_o(conv_en)
   );

   // Register writes; the status word is read only
   always @* begin
      next_conv_ch = conv_ch;
      next_clk_sel = clk_sel;
      next_pin_ctl = pin_ctl;
      if (wr_ok) begin
         if (hit_sc) begin
            next_conv_ch = wr_ch;
         end
         if (hit_clk) begin
            next_clk_sel = dat_i[1:0];
         end
         if (hit_pin) begin
            next_pin_ctl = dat_i[NPIN-1:0];
         end
      end
   end

   // Read data and handshake; unused upper bits read as zero
   always @* begin
      next_ack = req & mapped;
      next_err = req & ~mapped;
      next_dat = 32'h00000000;
      if (rd_ok) begin
         case (adr_i)
            `ACP_OFS_CONV_SC: next_dat = {27'h0000000, conv_ch};
            `ACP_OFS_CLK_CFG: next_dat = {30'h00000000, clk_sel};
            `ACP_OFS_PIN_LOW: next_dat = {{(32-NPIN){1'b0}}, pin_ctl};
            default: next_dat = {30'h00000000, conv_done_o, conv_active_o};
         endcase
      end
   end

   // Bus slave: one wait state, error on unmapped address
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h00000000;
         conv_ch <= `ACP_CONV_SC_RST;
         clk_sel <= `ACP_CLK_CFG_RST;
         pin_ctl <= {NPIN{1'b0}};
      end else begin
         ack_o <= next_ack;
         err_o <= next_err;
         dat_o <= next_dat;
         conv_ch <= next_conv_ch;
         clk_sel <= next_clk_sel;
         pin_ctl <= next_pin_ctl;
      end
   end

   // Conversion sequencer: a control write aborts any running conversion.
   // Writing all ones parks the converter; every other code restarts it,
   // including codes above the last wired channel, which then convert nothing useful.
   always @* begin
      next_state = state;
      next_cnt = cnt;
      next_start = 1'b0;
      next_channel = channel_o;
      if (wr_sc) begin
         next_channel = wr_ch;
         if (wr_ch != `ACP_CH_IDLE) begin
            next_state = ST_RUN;
            next_start = 1'b1;
            next_cnt = CONV_CYCLES[7:0];
         end else begin
            next_state = ST_IDLE;
            next_cnt = 8'h00;
         end
      end else begin
         case (state)
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            ST_RUN: begin
               // Counts only on enables, so a silent clock source stalls the conversion
               if (conv_en) begin
                  next_cnt = cnt - 8'h01;
                  if (cnt == 8'h01) begin
                     next_state = ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               next_state = ST_DONE;
            end
            default: begin
               next_state = ST_IDLE;
               next_cnt = 8'h00;
            end
         endcase
      end
   end

   // Status outputs are decoded from the next state so they leave flip-flops
   always @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         cnt <= 8'h00;
         conv_start_o <= 1'b0;
         conv_active_o <= 1'b0;
         conv_done_o <= 1'b0;
         channel_o <= `ACP_CONV_SC_RST;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         conv_start_o <= next_start;
         conv_active_o <= (next_state == ST_RUN);
         conv_done_o <= (next_state == ST_DONE);
         channel_o <= next_channel;
      end
   end

   // Pin hand-over per channel
   genvar i;
   generate
      for (i = 0; i < NPIN; i = i + 1) begin : g_pin
         always @(posedge clk_i) begin
            if (rst_i) begin
               pin_out_o[i] <= 1'b0;
               pin_oe_o[i] <= 1'b0;
               analog_sel_o[i] <= 1'b0;
            end else begin
               analog_sel_o[i] <= pin_ctl[i];
               pin_out_o[i] <= pin_ctl[i] ? 1'b0 : port_out_i[i];
               pin_oe_o[i] <= pin_ctl[i] ? 1'b0 : port_oe_i[i];
            end
         end
      end
   endgenerate
endmodule
